// *** logic/vsic_pkg.sv ***
// Constants, register map and source table of the interrupt controller
package vsic_pkg;
  localparam int NSRC = 32;
  localparam int AW   = 8;

  // Register byte offsets on the APB side
  localparam logic [AW-1:0] A_MASK   = 8'h00;
  localparam logic [AW-1:0] A_STAT   = 8'h04;
  localparam logic [AW-1:0] A_T0CMP  = 8'h08;
  localparam logic [AW-1:0] A_T1SET  = 8'h0c;
  localparam logic [AW-1:0] A_T1MODE = 8'h10;
  localparam logic [AW-1:0] A_TCOUNT = 8'h14;
  localparam logic [AW-1:0] A_VECT   = 8'h18;

  // Status bit positions
  localparam int B_VBIN   = 0;
  localparam int B_VBOUT  = 1;
  localparam int B_HBIN   = 2;
  localparam int B_TIM0   = 3;
  localparam int B_TIM1   = 4;
  localparam int B_CPEND  = 5;
  localparam int B_SOUND  = 6;
  localparam int B_SYSMGR = 7;
  localparam int B_PAD    = 8;
  localparam int B_DMA2   = 9;
  localparam int B_DMA1   = 10;
  localparam int B_DMA0   = 11;
  localparam int B_DMAILL = 12;
  localparam int B_SPRITE = 13;
  localparam int B_EXT0   = 16;
  localparam int NEXT     = 16;

  localparam logic [31:0] STAT_USED = 32'hffff3fff;
  localparam logic [31:0] MASK_RST  = 32'hffffffff;

  // Timer and vector register fields
  localparam int T0W        = 10;
  localparam int T1W        = 9;
  localparam int T1M_EN     = 0;
  localparam int T1M_EVERY  = 8;
  localparam int TC_T1_LSB  = 16;
  localparam int VR_VEC_LSB = 0;
  localparam int VR_LVL_LSB = 8;
  localparam int VR_VALID   = 16;

  // Dot clock for timer 1, derived from the system clock
  localparam int CLK_KHZ = 100000;
  localparam int DOT_KHZ = 7000;
  localparam int DOT_DIV = CLK_KHZ / DOT_KHZ;

  localparam logic [7:0] VEC_BASE_INT = 8'h40;
  localparam logic [7:0] VEC_BASE_EXT = 8'h50;
  localparam logic [3:0] LVL_EXT      = 4'h7;
  localparam logic [3:0] LVL_TAB [0:15] = '{
    4'hf, 4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9, 4'h8,
    4'h8, 4'h6, 4'h6, 4'h5, 4'h3, 4'h2, 4'h0, 4'h0};

  function automatic logic [3:0] level_of(input logic [4:0] b);
    return b[4] ? LVL_EXT : LVL_TAB[b[3:0]];
  endfunction

  function automatic logic [7:0] vec_of(input logic [4:0] b);
    return b[4] ? VEC_BASE_EXT + {4'h0, b[3:0]}
                : VEC_BASE_INT + {4'h0, b[3:0]};
  endfunction
endpackage

// *** logic/vsic_arb_if.sv ***
// Pending word to priority arbiter and the chosen source back
`timescale 1ns/100ps
interface vsic_arb_if;
  logic [31:0] pend;
  logic        valid;
  logic [4:0]  sel;
  logic [3:0]  lvl;
  modport req (output pend, input valid, sel, lvl);
  modport arb (input pend, output valid, sel, lvl);
endinterface

// *** logic/vsic_sync.sv ***
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module vsic_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clock,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  // Only the second stage reads the first
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= meta_d;
      o_sync <= sync_d;
    end
  end
endmodule

// *** logic/vsic_prio.sv ***
// Picks the pending source with the highest level, lowest bit on a tie
`timescale 1ns/100ps
module vsic_prio (
  vsic_arb_if.arb arb
);
  logic [3:0] best_lvl;
  logic [4:0] best_sel;

  always_comb begin
    best_lvl = 4'h0;
    best_sel = 5'h00;
    for (int b = 0; b < vsic_pkg::NSRC; b++) begin
      // Strict compare keeps the lower bit on equal levels
      if (arb.pend[b] && vsic_pkg::level_of(5'(b)) > best_lvl) begin
        best_lvl = vsic_pkg::level_of(5'(b));
        best_sel = 5'(b);
      end
    end
  end

  assign arb.valid = (best_lvl != 4'h0);
  assign arb.sel   = best_sel;
  assign arb.lvl   = best_lvl;
endmodule

// *** logic/vsic_top.sv ***
// Video-synchronised interrupt controller with APB register access
`timescale 1ns/100ps
module vsic_top #(
  parameter int DOT_DIV = vsic_pkg::DOT_DIV
) (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_vblank_in,
  input  wire logic        i_vblank_out,
  input  wire logic        i_hblank_in,
  input  wire logic        i_sound_req,
  input  wire logic        i_sysmgr_req,
  input  wire logic        i_pad_req,
  input  wire logic        i_sprite_end,
  input  wire logic [15:0] i_ext_irq,
  input  wire logic        i_prog_end,
  input  wire logic [2:0]  i_dma_end,
  input  wire logic        i_dma_illegal,
  output logic             o_irq_valid,
  output logic [7:0]       o_irq_vector,
  output logic [3:0]       o_irq_level
);
  localparam int NPIN = 7 + vsic_pkg::NEXT;
  localparam int DW   = $clog2(DOT_DIV + 1);
  localparam logic [DW-1:0] DOT_LAST = DW'(DOT_DIV - 1);

  if (DOT_DIV < 1) begin : g_bad_div
    $error("DOT_DIV must be at least one");
  end

  // Pin inputs: synchronise, then find rising edges
  // The edge register resets low like an idle pin, so reset makes no edge
  logic [NPIN-1:0] pin_s;
  logic [NPIN-1:0] pin_q;
  logic [NPIN-1:0] pin_d;
  logic [NPIN-1:0] pin_rise;

  vsic_sync #(.W(NPIN)) u_sync (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_async ({i_ext_irq, i_sprite_end, i_pad_req, i_sysmgr_req,
               i_sound_req, i_hblank_in, i_vblank_out, i_vblank_in}),
    .o_sync  (pin_s)
  );

  always_comb begin
    pin_d    = pin_s;
    pin_rise = pin_s & ~pin_q;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) pin_q <= '0;
    else         pin_q <= pin_d;
  end

  logic vbin_ev;
  logic vbout_ev;
  logic hbin_ev;
  assign vbin_ev  = pin_rise[0];
  assign vbout_ev = pin_rise[1];
  assign hbin_ev  = pin_rise[2];

  // APB slave: one wait state, answer registered
  logic [31:0] mask_q, mask_d;
  logic [31:0] stat_q, stat_d;
  logic [vsic_pkg::T0W-1:0] t0cmp_q, t0cmp_d;
  logic [vsic_pkg::T1W-1:0] t1set_q, t1set_d;
  logic t1_en_q, t1_en_d;
  logic t1_every_q, t1_every_d;
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  logic acc_done;
  logic wr_done;
  logic mapped;
  logic [31:0] rd_word;
  logic [31:0] stat_clr;

  logic [vsic_pkg::T0W-1:0] t0_cnt_q, t0_cnt_d;
  logic [vsic_pkg::T1W-1:0] t1_cnt_q, t1_cnt_d;
  logic [DW-1:0] dot_q, dot_d;
  logic line_hit_q, line_hit_d;
  logic dot_tick;
  logic t0_fire;
  logic t1_fire;
  logic [31:0] stat_set;

  vsic_arb_if arb ();

  // Completing edge: access phase with our ready already high
  // Ready stands one cycle only, so back-to-back accesses each wait once
  assign acc_done = i_psel & i_penable & o_pready;
  assign wr_done  = acc_done & i_pwrite;

  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    case (i_paddr)
      vsic_pkg::A_MASK:   rd_word = mask_q;
      vsic_pkg::A_STAT:   rd_word = stat_q;
      vsic_pkg::A_T0CMP:  rd_word = 32'(t0cmp_q);
      vsic_pkg::A_T1SET:  rd_word = 32'(t1set_q);
      vsic_pkg::A_T1MODE: begin
        rd_word[vsic_pkg::T1M_EN]    = t1_en_q;
        rd_word[vsic_pkg::T1M_EVERY] = t1_every_q;
      end
      vsic_pkg::A_TCOUNT: begin
        rd_word[vsic_pkg::T0W-1:0] = t0_cnt_q;
        rd_word[vsic_pkg::TC_T1_LSB +: vsic_pkg::T1W] = t1_cnt_q;
      end
      vsic_pkg::A_VECT: begin
        rd_word[vsic_pkg::VR_VEC_LSB +: 8] = o_irq_vector;
        rd_word[vsic_pkg::VR_LVL_LSB +: 4] = o_irq_level;
        rd_word[vsic_pkg::VR_VALID]        = o_irq_valid;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    pready_d   = i_psel & i_penable & ~o_pready;
    prdata_d   = pready_d ? rd_word : 32'h0000_0000;
    pslverr_d  = pready_d & ~mapped;
    mask_d     = mask_q;
    t0cmp_d    = t0cmp_q;
    t1set_d    = t1set_q;
    t1_en_d    = t1_en_q;
    t1_every_d = t1_every_q;
    stat_clr   = 32'h0000_0000;
    if (wr_done) begin
      case (i_paddr)
        vsic_pkg::A_MASK:   mask_d  = i_pwdata;
        vsic_pkg::A_STAT:   stat_clr = i_pwdata;
        vsic_pkg::A_T0CMP:  t0cmp_d = i_pwdata[vsic_pkg::T0W-1:0];
        vsic_pkg::A_T1SET:  t1set_d = i_pwdata[vsic_pkg::T1W-1:0];
        vsic_pkg::A_T1MODE: begin
          t1_en_d    = i_pwdata[vsic_pkg::T1M_EN];
          t1_every_d = i_pwdata[vsic_pkg::T1M_EVERY];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_pready   <= 1'b0;
      o_prdata   <= 32'h0000_0000;
      o_pslverr  <= 1'b0;
      mask_q     <= vsic_pkg::MASK_RST;
      t0cmp_q    <= '0;
      t1set_q    <= '0;
      t1_en_q    <= 1'b0;
      t1_every_q <= 1'b0;
    end else begin
      o_pready   <= pready_d;
      o_prdata   <= prdata_d;
      o_pslverr  <= pslverr_d;
      mask_q     <= mask_d;
      t0cmp_q    <= t0cmp_d;
      t1set_q    <= t1set_d;
      t1_en_q    <= t1_en_d;
      t1_every_q <= t1_every_d;
    end
  end

  // Line and dot timers
  // The matched line is remembered until the next line start for mode 0
  always_comb begin
    t0_cnt_d   = t0_cnt_q;
    t1_cnt_d   = t1_cnt_q;
    line_hit_d = line_hit_q;
    t0_fire    = 1'b0;
    t1_fire    = 1'b0;
    dot_tick   = (dot_q == DOT_LAST);
    dot_d      = dot_tick ? '0 : dot_q + DW'(1);
    if (vbout_ev) begin
      t0_cnt_d   = '0;
      line_hit_d = 1'b0;
    end else if (hbin_ev) begin
      t0_cnt_d   = t0_cnt_q + 1'b1;
      t0_fire    = (t0_cnt_d == t0cmp_q);
      line_hit_d = t0_fire;
    end
    if (hbin_ev) begin
      t1_cnt_d = t1set_q;
      dot_d    = '0;
    end else if (dot_tick && t1_cnt_q != '0) begin
      t1_cnt_d = t1_cnt_q - 1'b1;
      // Fires once on the step into zero, not while parked there
      t1_fire  = (t1_cnt_d == '0) && t1_en_q &&
                 (t1_every_q || line_hit_q);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      t0_cnt_q   <= '0;
      t1_cnt_q   <= '0;
      dot_q      <= '0;
      line_hit_q <= 1'b0;
    end else begin
      t0_cnt_q   <= t0_cnt_d;
      t1_cnt_q   <= t1_cnt_d;
      dot_q      <= dot_d;
      line_hit_q <= line_hit_d;
    end
  end

  // Sticky status: a new event beats a clear in the same cycle
  always_comb begin
    stat_set = 32'h0000_0000;
    stat_set[vsic_pkg::B_VBIN]   = vbin_ev;
    stat_set[vsic_pkg::B_VBOUT]  = vbout_ev;
    stat_set[vsic_pkg::B_HBIN]   = hbin_ev;
    stat_set[vsic_pkg::B_TIM0]   = t0_fire;
    stat_set[vsic_pkg::B_TIM1]   = t1_fire;
    stat_set[vsic_pkg::B_CPEND]  = i_prog_end;
    stat_set[vsic_pkg::B_SOUND]  = pin_rise[3];
    stat_set[vsic_pkg::B_SYSMGR] = pin_rise[4];
    stat_set[vsic_pkg::B_PAD]    = pin_rise[5];
    stat_set[vsic_pkg::B_DMA2]   = i_dma_end[2];
    stat_set[vsic_pkg::B_DMA1]   = i_dma_end[1];
    stat_set[vsic_pkg::B_DMA0]   = i_dma_end[0];
    stat_set[vsic_pkg::B_DMAILL] = i_dma_illegal;
    stat_set[vsic_pkg::B_SPRITE] = pin_rise[6];
    stat_set[vsic_pkg::B_EXT0 +: vsic_pkg::NEXT] = pin_rise[NPIN-1:7];
    stat_d = ((stat_q & ~stat_clr) | stat_set) & vsic_pkg::STAT_USED;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) stat_q <= 32'h0000_0000;
    else         stat_q <= stat_d;
  end

  // Arbitration over pending unmasked sources
  assign arb.pend = stat_q & ~mask_q;

  vsic_prio u_prio (
    .arb (arb.arb)
  );

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_irq_valid  <= 1'b0;
      o_irq_vector <= 8'h00;
      o_irq_level  <= 4'h0;
    end else begin
      o_irq_valid  <= arb.valid;
      o_irq_vector <= arb.valid ? vsic_pkg::vec_of(arb.sel) : 8'h00;
      o_irq_level  <= arb.lvl;
    end
  end

  // Checks run on the system clock and stay quiet while reset is high
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  chk_empty_bits: assert property (stat_q[15:14] == 2'b00)
    else $error("unused status bits set");
  chk_vector_map: assert property (arb.valid |=>
    o_irq_vector == vsic_pkg::vec_of($past(arb.sel)))
    else $error("vector does not match chosen source");
  chk_level_order: assert property (
    (arb.pend[vsic_pkg::B_VBIN] |=> o_irq_level == 4'hf) and
    (arb.pend[vsic_pkg::B_SPRITE] && arb.pend[31:14] == '0 &&
     arb.pend[12:0] == '0 |=> o_irq_level == 4'h2))
    else $error("wrong level presented");
  chk_vblank_set: assert property (vbin_ev |=> stat_q[vsic_pkg::B_VBIN])
    else $error("vertical blank start not recorded");
  chk_hblank_set: assert property (hbin_ev |=> stat_q[vsic_pkg::B_HBIN])
    else $error("horizontal blank start not recorded");
  chk_t0_clear: assert property (vbout_ev |=> t0_cnt_q == '0)
    else $error("line counter not cleared");
  chk_t0_count: assert property (hbin_ev && !vbout_ev |=>
    t0_cnt_q == $past(t0_cnt_q) + 1'b1)
    else $error("line counter did not step");
  chk_t0_match: assert property (hbin_ev && !vbout_ev &&
    t0_cnt_q + 1'b1 == t0cmp_q |=> stat_q[vsic_pkg::B_TIM0])
    else $error("timer 0 match lost");
  chk_t1_reload: assert property (hbin_ev |=> t1_cnt_q == $past(t1set_q))
    else $error("timer 1 not reloaded");
  chk_dot_rate: assert property (!hbin_ev && !dot_tick |=>
    t1_cnt_q == $past(t1_cnt_q))
    else $error("timer 1 moved off the dot tick");
  chk_t1_zero: assert property (t1_fire |=>
    stat_q[vsic_pkg::B_TIM1] && t1_cnt_q == '0)
    else $error("timer 1 zero not recorded");
  chk_t1_mode: assert property ($rose(stat_q[vsic_pkg::B_TIM1]) |->
    $past(t1_en_q) && ($past(t1_every_q) || $past(line_hit_q)))
    else $error("timer 1 fired off its line");
  chk_prog_end: assert property (i_prog_end |=> stat_q[vsic_pkg::B_CPEND])
    else $error("program end not recorded");
  chk_dma_done: assert property (i_dma_end[0] |=>
    stat_q[vsic_pkg::B_DMA0]) else $error("dma level 0 end lost");
  chk_dma_lvl1: assert property (i_dma_end[1] |=>
    stat_q[vsic_pkg::B_DMA1]) else $error("dma level 1 end lost");
  chk_dma_lvl2: assert property (i_dma_end[2] |=>
    stat_q[vsic_pkg::B_DMA2]) else $error("dma level 2 end lost");
  chk_dma_bad: assert property (i_dma_illegal |=>
    stat_q[vsic_pkg::B_DMAILL]) else $error("dma illegal lost");
  chk_sprite_set: assert property (pin_rise[6] |=>
    stat_q[vsic_pkg::B_SPRITE]) else $error("sprite end lost");
  chk_sound_pass: assert property ($rose(i_sound_req) ##1 i_sound_req
    ##1 i_sound_req |-> ##[1:2] stat_q[vsic_pkg::B_SOUND])
    else $error("sound request lost");
  chk_sticky_hold: assert property (!wr_done |=>
    (stat_q & $past(stat_q)) == $past(stat_q))
    else $error("status bit dropped without clear");

  cov_t1_every: cover property (t1_fire && t1_every_q);
  cov_t1_point: cover property (t1_fire && !t1_every_q);
  cov_clear_race: cover property (wr_done && |(stat_clr & stat_set));
  cov_ext_irq: cover property (o_irq_valid && o_irq_vector[4]);
  cov_t0_hit: cover property (t0_fire);
endmodule

// *** tb/vsic_cpu_model.sv ***
// Processor-side model: APB master that runs one transfer per request
`timescale 1ns/100ps
module vsic_cpu_model (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_go,
  input  wire logic        i_write,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata,
  output logic [31:0]      o_rdata,
  output logic             o_slverr,
  output logic             o_done
);
  logic [1:0] st_q;
  assign o_done = (st_q == 2'h3);
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st_q <= 2'h0;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      o_pwrite <= 1'b0;
      o_paddr <= 8'h00;
      o_pwdata <= 32'h0;
    end else begin
      case (st_q)
        2'h0: if (i_go) begin
          o_psel <= 1'b1;
          o_pwrite <= i_write;
          o_paddr <= i_addr;
          o_pwdata <= i_wdata;
          st_q <= 2'h1;
        end
        2'h1: begin
          o_penable <= 1'b1;
          st_q <= 2'h2;
        end
        2'h2: if (i_pready) begin
          o_psel <= 1'b0;
          o_penable <= 1'b0;
          // Released lines show garbage, not the last request
          o_paddr <= ~o_paddr;
          o_pwdata <= ~o_pwdata;
          o_rdata <= i_prdata;
          o_slverr <= i_pslverr;
          st_q <= 2'h3;
        end
        default: if (!i_go) begin
          st_q <= 2'h0;
        end
      endcase
    end
  end
endmodule

// *** tb/video_synced_interrupt_controller_tb.sv ***
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
module video_synced_interrupt_controller_tb;
  logic        clk, rst, go, wr, psel, pen, pwr, pready, pslverr;
  logic        done, serr, irq_v;
  logic [7:0]  addr, paddr, irq_vec;
  logic [3:0]  irq_lvl;
  logic [31:0] wdata, ev, pwdata, prdata, rdata;
  int          fail_count, num_checks;
  logic [3:0]  lv [0:13] = '{4'hf, 4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9,
                             4'h8, 4'h8, 4'h6, 4'h6, 4'h5, 4'h3, 4'h2};

  vsic_top #(.DOT_DIV(2)) vsic_top_i (
    .i_clock(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_vblank_in(ev[0]),
    .i_vblank_out(ev[1]), .i_hblank_in(ev[2]), .i_sound_req(ev[6]),
    .i_sysmgr_req(ev[7]), .i_pad_req(ev[8]), .i_sprite_end(ev[13]),
    .i_ext_irq(ev[31:16]), .i_prog_end(ev[5]),
    .i_dma_end({ev[9], ev[10], ev[11]}), .i_dma_illegal(ev[12]),
    .o_irq_valid(irq_v), .o_irq_vector(irq_vec), .o_irq_level(irq_lvl));

  vsic_cpu_model vsic_cpu_model_i (
    .i_clock(clk), .i_reset(rst), .i_go(go), .i_write(wr), .i_addr(addr),
    .i_wdata(wdata), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
    .o_paddr(paddr), .o_pwdata(pwdata), .o_rdata(rdata), .o_slverr(serr),
    .o_done(done));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    while (done !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, done}, 32'h1, "bus answer");
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, string what);
    apb(1'b0, a, 32'h0);
    chk(rdata, e, what);
  endtask

  // Pins reach status three clocks after they rise, and every source is held four
  task automatic pulse(input logic [31:0] b);
    @(posedge clk);
    ev <= b;
    repeat (4) @(posedge clk);
    ev <= 32'h0;
    repeat (3) @(posedge clk);
  endtask

  task automatic irq(input logic v, input logic [7:0] vec, input logic [3:0] l);
    @(negedge clk);
    chk({23'h0, irq_v, irq_vec}, {23'h0, v, vec}, "irq vector");
    chk({28'h0, irq_lvl}, {28'h0, l}, "irq level");
  endtask

  task automatic t_reset();
    rd(8'h00, 32'hffffffff, "mask reset");
    rd(8'h04, 32'h0, "status reset");
    rd(8'h1c, 32'h0, "unmapped read");
    chk({31'h0, serr}, 32'h1, "unmapped error");
    irq(1'b0, 8'h00, 4'h0);
  endtask

  task automatic t_sources();
    logic [7:0] v;
    logic [3:0] l;
    apb(1'b1, 8'h00, 32'h0);
    for (int b = 0; b < 32; b++) begin
      if (b == 3 || b == 4 || b == 14 || b == 15) continue;
      v = (b < 16) ? 8'h40 + 8'(b) : 8'h50 + 8'(b - 16);
      l = (b < 16) ? lv[b] : 4'h7;
      pulse(32'h1 << b);
      irq(1'b1, v, l);
      rd(8'h04, 32'h1 << b, "status bit");
      apb(1'b1, 8'h04, 32'h1 << b);
      rd(8'h04, 32'h0, "status clear");
    end
  endtask

  task automatic t_prio();
    apb(1'b1, 8'h00, 32'hffffffff);
    pulse(32'h800);
    irq(1'b0, 8'h00, 4'h0);
    rd(8'h04, 32'h800, "sticky status");
    apb(1'b1, 8'h00, 32'h0);
    irq(1'b1, 8'h4b, 4'h5);
    pulse(32'h10000);
    irq(1'b1, 8'h50, 4'h7);
    pulse(32'h180);
    irq(1'b1, 8'h47, 4'h8);
    pulse(32'h40);
    irq(1'b1, 8'h46, 4'h9);
    rd(8'h18, 32'h10946, "vector register");
    apb(1'b1, 8'h00, 32'h40);
    irq(1'b1, 8'h47, 4'h8);
    apb(1'b1, 8'h04, 32'hffffffff);
    irq(1'b0, 8'h00, 4'h0);
  endtask

  task automatic t_timer0();
    apb(1'b1, 8'h00, 32'hfffffff7);
    apb(1'b1, 8'h08, 32'h3);
    pulse(32'h2);
    rd(8'h14, 32'h0, "timer0 cleared");
    pulse(32'h4);
    pulse(32'h4);
    rd(8'h14, 32'h2, "timer0 count");
    irq(1'b0, 8'h00, 4'h0);
    pulse(32'h4);
    irq(1'b1, 8'h43, 4'hc);
    pulse(32'h2);
    rd(8'h14, 32'h0, "timer0 cleared again");
  endtask

  // Reload of 9 at two clocks a dot lands near 22 clocks after the pin
  task automatic t1_line(input logic fire);
    apb(1'b1, 8'h04, 32'hffffffff);
    pulse(32'h4);
    repeat (6) @(posedge clk);
    irq(1'b0, 8'h00, 4'h0);
    repeat (14) @(posedge clk);
    @(negedge clk);
    chk({31'h0, irq_v}, {31'h0, fire}, "timer1 fire");
  endtask

  task automatic t_timer1();
    apb(1'b1, 8'h00, 32'hffffffef);
    apb(1'b1, 8'h0c, 32'h9);
    apb(1'b1, 8'h10, 32'h101);
    t1_line(1'b1);
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b1, 8'h08, 32'h2);
    pulse(32'h2);
    t1_line(1'b0);
    t1_line(1'b1);
    t1_line(1'b0);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    fail_count = 0;
    num_checks = 0;
    rst = 1'b1;
    go = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    ev = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_sources();
    t_prio();
    t_timer0();
    t_timer1();
    results();
  end
endmodule
